// ---- design/cab_core.sv ----
/*
 * execution block for add, add with carry, arithmetic shift, bit clear,
 * skip on low bit and relative jump, with an apb register slave.
 * assumes the data file answers file_rdata_in combinationally for
 * file_addr_in, and the fetch path follows program_counter_out.
 */
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "cab_params.svh"

// What this block does
// - add sums accumulator and the file register at a 7-bit address, updating c, dc, z.
// - destination bit 0 puts the result in the accumulator except for bit clear, which always writes back; 1 writes it back to the file.
// - add with carry sums accumulator, file register and carry, updating c, dc, z.
// - arithmetic shift moves bits 7:1 to 6:0, bit 0 into carry, updates c and z.
// - arithmetic shift keeps the top bit equal to the original top bit.
// - bit clear zeroes the selected bit 0..7 and leaves other bits and flags alone.
// - skip on low bit runs on if the bit is one, else drops the next op for an idle cycle.
// - relative jump adds a signed 9-bit offset to the incremented program counter.
// - relative jump always takes two cycles and leaves every flag unchanged.
// - a program counter change or true test costs a second cycle run as idle.
module cab_core
  import cab_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // instruction issue
  input wire logic op_valid_in,
  input wire cab_op_t op_code_in,
  input wire logic dest_in,
  input wire logic [2:0] bit_idx_in,
  input wire logic [8:0] offset_in,
  output logic op_ready_out,
  output logic idle_cycle_out,
  // data file
  input wire logic [6:0] file_addr_in,
  input wire logic [7:0] file_rdata_in,
  output logic file_we_out,
  output logic [6:0] file_waddr_out,
  output logic [7:0] file_wdata_out,
  // fetch
  output logic [14:0] program_counter_out
);

  // ************************************
  // state
  // ************************************
  cab_state_t state_q, state_d;
  logic [7:0] acc_q, acc_d;
  logic [2:0] stat_q, stat_d;
  logic [14:0] pc_q, pc_d;
  logic run_q, run_d;
  logic we_q, we_d;
  logic [6:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [31:0] rdata_q, rdata_d;
  logic take, apb_wr, apb_setup;
  logic [7:0] alu_res;
  logic alu_c, alu_dc, alu_z, upd_cz, upd_dc;

  // address decode shared by reads and writes
  function automatic logic reg_hit(input logic [11:0] a);
    reg_hit = (a == `CAB_ACC_OFS) || (a == `CAB_STAT_OFS) ||
              (a == `CAB_PC_OFS) || (a == `CAB_CTRL_OFS);
  endfunction

  // ************************************
  // alu
  // ************************************
  cab_alu u_alu (
    .op_in(op_code_in),
    .acc_in(acc_q),
    .file_in(file_rdata_in),
    .carry_in(stat_q[`CAB_ST_C]),
    .bit_idx_in(bit_idx_in),
    .res_out(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z),
    .upd_cz_out(upd_cz),
    .upd_dc_out(upd_dc)
  );

  // handshake terms
  assign op_ready_out = (state_q == CAB_ST_EXEC) && run_q;
  assign take = op_valid_in && op_ready_out;
  assign apb_setup = psel_in && !penable_in;
  assign apb_wr = psel_in && penable_in && pwrite_in && reg_hit(paddr_in);
  assign pready_out = 1'h1;
  assign pslverr_out = psel_in && penable_in && !reg_hit(paddr_in);
  assign prdata_out = rdata_q;
  assign idle_cycle_out = (state_q == CAB_ST_IDLE);
  assign file_we_out = we_q;
  assign file_waddr_out = waddr_q;
  assign file_wdata_out = wdata_q;
  assign program_counter_out = pc_q;

  // ************************************
  // next-state logic
  // ************************************
  always_comb begin
    state_d = state_q;
    acc_d = acc_q;
    stat_d = stat_q;
    pc_d = pc_q;
    run_d = run_q;
    we_d = 1'h0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    // read data captured in the setup cycle
    if (apb_setup) begin
      case (paddr_in)
        `CAB_ACC_OFS: rdata_d = {24'h000000, acc_q};
        `CAB_STAT_OFS: rdata_d = {29'h00000000, stat_q};
        `CAB_PC_OFS: rdata_d = {17'h00000, pc_q};
        `CAB_CTRL_OFS: rdata_d = {31'h00000000, run_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
    // software writes; the core below overrides on a clash
    if (apb_wr) begin
      case (paddr_in)
        `CAB_ACC_OFS: acc_d = pwdata_in[7:0];
        `CAB_STAT_OFS: stat_d = pwdata_in[2:0];
        `CAB_PC_OFS: pc_d = pwdata_in[14:0];
        `CAB_CTRL_OFS: run_d = pwdata_in[`CAB_CTRL_RUN];
        default: run_d = run_q;
      endcase
    end
    case (state_q)
      CAB_ST_EXEC: begin
        if (take) begin
          pc_d = pc_q + 15'h0001;
          case (op_code_in)
            CAB_OP_ADD, CAB_OP_ADDC, CAB_OP_ASR, CAB_OP_BCLR: begin
              // destination select bit clear always writes back
              if (dest_in || op_code_in == CAB_OP_BCLR) begin
                we_d = 1'h1;
                waddr_d = file_addr_in;
                wdata_d = alu_res;
              end else begin
                acc_d = alu_res;
              end
              if (upd_cz) begin
                stat_d[`CAB_ST_C] = alu_c;
                stat_d[`CAB_ST_Z] = alu_z;
              end
              if (upd_dc) begin
                stat_d[`CAB_ST_DC] = alu_dc;
              end
            end
            CAB_OP_SKIPLOW: begin
              if (!file_rdata_in[bit_idx_in]) begin
                pc_d = pc_q + 15'h0002; // next op dropped
                state_d = CAB_ST_IDLE;
              end
            end
            CAB_OP_JUMP: begin
              pc_d = pc_q + 15'h0001 + {{6{offset_in[8]}}, offset_in};
              state_d = CAB_ST_IDLE; // two cycles, flags kept
            end
            default: begin
              pc_d = pc_q + 15'h0001;
            end
          endcase
        end
      end
      CAB_ST_IDLE: begin
        state_d = CAB_ST_EXEC; // idle second cycle
      end
      default: begin
        state_d = CAB_ST_EXEC;
      end
    endcase
  end

  // ************************************
  // registers
  // ************************************
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= CAB_ST_EXEC;
      acc_q <= `CAB_ACC_RST;
      stat_q <= `CAB_STAT_RST;
      pc_q <= `CAB_PC_RST;
      run_q <= `CAB_CTRL_RST;
      we_q <= 1'h0;
      waddr_q <= 7'h00;
      wdata_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      acc_q <= acc_d;
      stat_q <= stat_d;
      pc_q <= pc_d;
      run_q <= run_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
    end
  end

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  add_to_acc_a: assert property (
    take && op_code_in == CAB_OP_ADD && !dest_in |=>
      acc_q == 8'($past(acc_q) + $past(file_rdata_in)))
    else $error("add result wrong in accumulator");

  dest_file_a: assert property (
    take && dest_in && op_code_in inside {CAB_OP_ADD, CAB_OP_ADDC, CAB_OP_ASR} |=>
      file_we_out && file_waddr_out == $past(file_addr_in) && acc_q == $past(acc_q))
    else $error("file destination not honoured");

  addc_carry_a: assert property (
    take && op_code_in == CAB_OP_ADDC |=> stat_q[`CAB_ST_C] ==
      $past(({1'h0, acc_q} + {1'h0, file_rdata_in} + {8'h00, stat_q[`CAB_ST_C]}) > 9'h0FF))
    else $error("add with carry flag wrong");

  shift_carry_a: assert property (
    take && op_code_in == CAB_OP_ASR |=> stat_q[`CAB_ST_C] == $past(file_rdata_in[0]))
    else $error("shift carry wrong");

  sign_keep_a: assert property (
    take && op_code_in == CAB_OP_ASR && dest_in |=>
      file_wdata_out == {$past(file_rdata_in[7]), $past(file_rdata_in[7:1])})
    else $error("shift lost sign");

  bit_clear_a: assert property (
    take && op_code_in == CAB_OP_BCLR && !apb_wr |=> file_we_out &&
      file_wdata_out == ($past(file_rdata_in) & ~(8'h01 << $past(bit_idx_in))) &&
      stat_q == $past(stat_q))
    else $error("bit clear wrong");

  skip_idle_a: assert property (
    take && op_code_in == CAB_OP_SKIPLOW && !file_rdata_in[bit_idx_in] |=>
      idle_cycle_out && !op_ready_out && pc_q == $past(pc_q) + 15'h0002 ##1 !idle_cycle_out)
    else $error("skip did not idle");

  no_skip_a: assert property (
    take && op_code_in == CAB_OP_SKIPLOW && file_rdata_in[bit_idx_in] |=> !idle_cycle_out)
    else $error("skip on high bit");

  jump_target_a: assert property (
    take && op_code_in == CAB_OP_JUMP |=>
      pc_q == 15'($past(pc_q) + 15'h0001 + {{6{$past(offset_in[8])}}, $past(offset_in)}))
    else $error("jump target wrong");

  jump_flags_a: assert property (
    take && op_code_in == CAB_OP_JUMP && !apb_wr |=> stat_q == $past(stat_q) && idle_cycle_out)
    else $error("jump changed flags");

  idle_once_a: assert property (
    idle_cycle_out |-> !op_ready_out ##1 !idle_cycle_out)
    else $error("idle cycle not single");

  zero_flag_a: assert property (
    take && op_code_in inside {CAB_OP_ADD, CAB_OP_ADDC} |=>
      stat_q[`CAB_ST_Z] == (8'($past(acc_q) + $past(file_rdata_in) +
      $past({7'h00, stat_q[`CAB_ST_C] && op_code_in == CAB_OP_ADDC})) == 8'h00))
    else $error("zero flag wrong");

  add_cov_c: cover property (take && op_code_in == CAB_OP_ADDC && dest_in);
  skip_cov_c: cover property (take && op_code_in == CAB_OP_SKIPLOW ##1 idle_cycle_out);
  jump_cov_c: cover property (take && op_code_in == CAB_OP_JUMP && offset_in[8]);
  apb_cov_c: cover property (apb_wr && take);

endmodule

// ---- design/cab_params.svh ----
/*
 * constants for the arithmetic, bit and branch execution block:
 * register offsets, field positions and reset values.
 * assumes inclusion by bare name from design and test files.
 */
`ifndef CAB_PARAMS_SVH
`define CAB_PARAMS_SVH

// ************************************
// register byte offsets (apb, 32-bit words)
// ************************************
`define CAB_ACC_OFS 12'h000
`define CAB_STAT_OFS 12'h004
`define CAB_PC_OFS 12'h008
`define CAB_CTRL_OFS 12'h00C

// ************************************
// status fields and reset values
// ************************************
`define CAB_ST_C 0
`define CAB_ST_DC 1
`define CAB_ST_Z 2
`define CAB_CTRL_RUN 0
`define CAB_ACC_RST 8'h00
`define CAB_STAT_RST 3'h0
`define CAB_PC_RST 15'h0000
`define CAB_CTRL_RST 1'h1

`endif

// ---- design/cab_pkg.sv ----
/*
 * types shared by the execution block and its alu.
 * assumes nothing beyond a systemverilog compiler.
 */
package cab_pkg;

  // operation selector presented with each issued instruction
  typedef enum logic [2:0] {
    CAB_OP_IDLE = 3'h0,
    CAB_OP_ADD = 3'h1,
    CAB_OP_ADDC = 3'h2,
    CAB_OP_ASR = 3'h3,
    CAB_OP_BCLR = 3'h4,
    CAB_OP_SKIPLOW = 3'h5,
    CAB_OP_JUMP = 3'h6
  } cab_op_t;

  // execute / forced idle second cycle
  typedef enum logic [1:0] {
    CAB_ST_EXEC = 2'h0,
    CAB_ST_IDLE = 2'h1
  } cab_state_t;

endpackage

// ---- design/cab_alu.sv ----
/*
 * combinational alu: result and flag values for one operation.
 * assumes the caller registers the outputs and applies the masks.
 */
`timescale 1ns/10ps

module cab_alu
  import cab_pkg::*;
(
  // operation and operands
  input wire cab_op_t op_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] file_in,
  input wire logic carry_in,
  input wire logic [2:0] bit_idx_in,
  // results
  output logic [7:0] res_out,
  output logic c_out,
  output logic dc_out,
  output logic z_out,
  output logic upd_cz_out,
  output logic upd_dc_out
);

  // sum with carry-in, one bit wider than operands
  function automatic logic [8:0] add_ci(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci);
    add_ci = {1'h0, a} + {1'h0, b} + {8'h00, ci};
  endfunction

  logic [8:0] sum9;
  logic [8:0] nib9;
  logic cin;

  // operation select and flag generation
  always_comb begin
    cin = (op_in == CAB_OP_ADDC) ? carry_in : 1'h0;
    sum9 = add_ci(acc_in, file_in, cin);
    nib9 = add_ci({4'h0, acc_in[3:0]}, {4'h0, file_in[3:0]}, cin);
    res_out = file_in;
    c_out = carry_in;
    dc_out = nib9[4]; // carry out of bit 3
    upd_cz_out = 1'h0;
    upd_dc_out = 1'h0;
    case (op_in)
      CAB_OP_ADD, CAB_OP_ADDC: begin
        res_out = sum9[7:0];
        c_out = sum9[8];
        upd_cz_out = 1'h1;
        upd_dc_out = 1'h1;
      end
      CAB_OP_ASR: begin
        res_out = {file_in[7], file_in[7:1]}; // sign kept
        c_out = file_in[0];
        upd_cz_out = 1'h1;
      end
      CAB_OP_BCLR: begin
        res_out = file_in & ~(8'h01 << bit_idx_in); // flags untouched
      end
      default: begin
        res_out = file_in;
      end
    endcase
    z_out = (res_out == 8'h00);
  end

endmodule

// ---- test/cab_file_model.sv ----
/*
 * data file model: 128 bytes, read answers in the same cycle,
 * write on the one-cycle pulse. assumes the bench presets mem.
 */
`timescale 1ns/10ps

module cab_file_model (
  // clock
  input wire logic sys_clk_in,
  // read and write sides
  input wire logic [6:0] raddr_in,
  input wire logic we_in,
  input wire logic [6:0] waddr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:127];
  // combinational read of the offered address
  assign rdata_out = mem[raddr_in];
  // write back on the pulse
  always @(posedge sys_clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end
endmodule

// ---- test/core_arith_bit_branch_ops_tb_top.sv ----
/*
 * bench for the execution block: apb and issue tasks, file model.
 * assumes one-cycle issue effects; apb transfers wait on pready.
 */
`timescale 1ns/10ps
`include "cab_params.svh"

module core_arith_bit_branch_ops_tb_top
  import cab_pkg::*;
;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0, prd, rd;
  logic prdy, perr, er, ov = 1'h0, od = 1'h0, ordy, oidl, fwe, idl, rdy;
  cab_op_t oc = CAB_OP_IDLE;
  logic [2:0] ob = 3'h0;
  logic [8:0] ok = 9'h000;
  logic [6:0] fa = 7'h00, fwa;
  logic [7:0] frd, fwd, e8;
  logic [14:0] pc, p0;
  int fail_count = 0, n_checks = 0;

  // clock
  always #5 clk = ~clk;

  cab_core u_dut (.sys_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .op_valid_in(ov), .op_code_in(oc), .dest_in(od), .bit_idx_in(ob),
    .offset_in(ok), .op_ready_out(ordy), .idle_cycle_out(oidl), .file_addr_in(fa),
    .file_rdata_in(frd), .file_we_out(fwe), .file_waddr_out(fwa), .file_wdata_out(fwd),
    .program_counter_out(pc));
  cab_file_model u_file (.sys_clk_in(clk), .raddr_in(fa), .we_in(fwe), .waddr_in(fwa),
    .wdata_in(fwd), .rdata_out(frd));

  // ************************************
  // tasks
  // ************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  // one apb transfer, answer taken at the completing edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pen <= 1'h0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (prdy !== 1'h1) @(posedge clk);
    rd = prd;
    er = perr;
    psel <= 1'h0;
    pen <= 1'h0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask

  // issue one op, record idle and ready of the cycle after it
  task automatic op(input cab_op_t c, input logic ds, input logic [2:0] b,
    input logic [8:0] k, input logic [6:0] f);
    @(posedge clk);
    ov <= 1'h1;
    oc <= c;
    od <= ds;
    ob <= b;
    ok <= k;
    fa <= f;
    @(negedge clk);
    while (ordy !== 1'h1) @(negedge clk);
    @(posedge clk);
    ov <= 1'h0;
    @(negedge clk);
    idl = oidl;
    rdy = ordy;
    @(negedge clk);
  endtask

  // watchdog
  initial begin
    #20000;
    fail_count++;
    end_sim;
  end

  // ************************************
  // tests
  // ************************************
  initial begin
    u_file.mem[5] = 8'h01;
    u_file.mem[6] = 8'hF0;
    u_file.mem[7] = 8'h0F;
    u_file.mem[8] = 8'h81;
    u_file.mem[9] = 8'h01;
    u_file.mem[10] = 8'hFF;
    u_file.mem[11] = 8'h08;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    rchk(`CAB_ACC_OFS, 32'h0);
    rchk(`CAB_STAT_OFS, 32'h0);
    rchk(`CAB_PC_OFS, 32'h0);
    rchk(`CAB_CTRL_OFS, 32'h1);
    apb(1'h0, 12'h010, 32'h0);
    chk(32'(er), 32'h1);
    $display("test regs done");
    // adds: dc only, carry and zero to file, carry-in
    apb(1'h1, `CAB_ACC_OFS, 32'h0F);
    op(CAB_OP_ADD, 1'h0, 3'h0, 9'h000, 7'h05);
    chk(32'(pc), 32'h1);
    rchk(`CAB_ACC_OFS, 32'h10);
    rchk(`CAB_STAT_OFS, 32'h2);
    op(CAB_OP_ADD, 1'h1, 3'h0, 9'h000, 7'h06);
    chk(32'(u_file.mem[6]), 32'h0);
    rchk(`CAB_ACC_OFS, 32'h10);
    rchk(`CAB_STAT_OFS, 32'h5);
    op(CAB_OP_ADDC, 1'h0, 3'h0, 9'h000, 7'h07);
    rchk(`CAB_ACC_OFS, 32'h20);
    rchk(`CAB_STAT_OFS, 32'h2);
    $display("test add done");
    // shifts, sign kept
    op(CAB_OP_ASR, 1'h1, 3'h0, 9'h000, 7'h08);
    chk(32'(u_file.mem[8]), 32'hC0);
    rchk(`CAB_STAT_OFS, 32'h3);
    op(CAB_OP_ASR, 1'h0, 3'h0, 9'h000, 7'h09);
    rchk(`CAB_ACC_OFS, 32'h0);
    rchk(`CAB_STAT_OFS, 32'h7);
    $display("test shift done");
    // clear each bit in turn
    e8 = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      op(CAB_OP_BCLR, 1'h0, 3'(b), 9'h000, 7'h0A);
      e8 = e8 & ~(8'h01 << b);
      chk(32'(u_file.mem[10]), 32'(e8));
    end
    rchk(`CAB_STAT_OFS, 32'h7);
    $display("test clear done");
    // skip taken and not taken
    p0 = pc;
    op(CAB_OP_SKIPLOW, 1'h0, 3'h0, 9'h000, 7'h0B);
    chk(32'(pc), 32'(p0 + 15'h2));
    chk({30'h0, idl, rdy}, 32'h2);
    p0 = pc;
    op(CAB_OP_SKIPLOW, 1'h0, 3'h3, 9'h000, 7'h0B);
    chk(32'(pc), 32'(p0 + 15'h1));
    chk({30'h0, idl, rdy}, 32'h1);
    p0 = pc;
    op(CAB_OP_IDLE, 1'h0, 3'h0, 9'h000, 7'h00);
    chk(32'(pc), 32'(p0 + 15'h1));
    chk({30'h0, idl, rdy}, 32'h1);
    $display("test skip done");
    // jumps at both ends of the range
    apb(1'h1, `CAB_PC_OFS, 32'h200);
    op(CAB_OP_JUMP, 1'h0, 3'h0, 9'h100, 7'h00);
    chk(32'(pc), 32'h101);
    chk({30'h0, idl, rdy}, 32'h2);
    op(CAB_OP_JUMP, 1'h0, 3'h0, 9'h0FF, 7'h00);
    chk(32'(pc), 32'h201);
    rchk(`CAB_STAT_OFS, 32'h7);
    apb(1'h1, `CAB_CTRL_OFS, 32'h0);
    @(negedge clk);
    chk(32'(ordy), 32'h0);
    $display("test jump done");
    end_sim;
  end
endmodule
